/* design/sarc_regs.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the package and design files of the converter control
`ifndef SARC_REGS_SVH
`define SARC_REGS_SVH

// Byte offsets on the register bus
`define SARC_OFF_CTRL      8'h00
`define SARC_OFF_STATUS    8'h04
`define SARC_OFF_RESULT    8'h08
`define SARC_OFF_IRQ_STAT  8'h0C
`define SARC_OFF_IRQ_MASK  8'h10

// Control fields
`define SARC_CTRL_START    0
`define SARC_CTRL_SHORT    1

// Status fields
`define SARC_STAT_BUSY     0
`define SARC_STAT_SHORT    1
`define SARC_STAT_VALID    2
`define SARC_STAT_STATE    4

// Interrupt fields
`define SARC_IRQ_DONE      0
`define SARC_IRQ_IGNORED   1
`define SARC_IRQ_W         2

// Reset values
`define SARC_RST_SHORT     1'h0
`define SARC_RST_MASK      2'h0
`define SARC_RST_RESULT    12'h000

// Result layout
`define SARC_RES_W         12
`define SARC_MSB_IDX       4'hB
`define SARC_SHORT_LAST    4'h4
`define SARC_ZERO_IDX      4'h0
`define SARC_SHORT_FILL    4'h8

// Timing: one bit trial of the internal conversion clock
`define SARC_MCLK_NS       40
`define SARC_BIT_NS        600
`define SARC_BIT_CYC       ((`SARC_BIT_NS + `SARC_MCLK_NS - 1) / `SARC_MCLK_NS)
`define SARC_TICK_W        5

`endif

/* design/sarc_pkg.sv */
// Types shared by the converter control and its bit sequencer
// Assumes sarc_regs.svh supplies the widths
`include "sarc_regs.svh"

package sarc_pkg;

  typedef logic [`SARC_RES_W-1:0] sarc_word_t;

  // Gray coded along idle, clear, run, done
  typedef enum logic [1:0]
  {
    st_idle  = 2'b00,
    st_clear = 2'b01,
    st_run   = 2'b11,
    st_done  = 2'b10
  } sarc_state_e;

  // Converter control pins and comparator, all asynchronous to mclk
  typedef struct packed
  {
    logic comp_below;
    logic width_sel;
    logic length_byte_select;
    logic read_convert;
    logic select_n;
    logic strobe_en;
  } sarc_pins_s;

endpackage

/* design/sarc_seq.sv */
// Successive approximation sequencer: register, bit index, trial clock
// Assumes comp_below is already synchronised to mclk
`timescale 1ns/100ps
`include "sarc_regs.svh"

module sarc_seq
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         mclk_en,
  // Control
  input  wire logic         clear,
  input  wire logic         run,
  input  wire logic         short_cycle,
  input  wire logic         comp_below,
  // Result
  output sarc_pkg::sarc_word_t successive_approx_register,
  output sarc_pkg::sarc_word_t trial,
  output logic              eoc
);
  import sarc_pkg::*;

  localparam logic [`SARC_TICK_W-1:0] BIT_LAST = `SARC_TICK_W'(`SARC_BIT_CYC - 1);

  logic [`SARC_TICK_W-1:0] tick_cnt_r;
  logic [3:0]              idx_r;
  sarc_word_t              successive_approx_register_r;
  logic                    eoc_r;
  logic                    tick;
  logic                    last;

  assign tick  = run & (tick_cnt_r == BIT_LAST);
  assign last  = idx_r == (short_cycle ? `SARC_SHORT_LAST : `SARC_ZERO_IDX);
  assign successive_approx_register = successive_approx_register_r;
  assign trial = run ? (successive_approx_register_r | (`SARC_RES_W'(1) << idx_r))
                     : successive_approx_register_r;
  assign eoc   = eoc_r;

  // Trial clock only runs while a conversion is running
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      tick_cnt_r <= '0;
    else if (mclk_en)
    begin
      if (clear || !run || tick)
        tick_cnt_r <= '0;
      else
        tick_cnt_r <= tick_cnt_r + `SARC_TICK_W'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      idx_r <= `SARC_MSB_IDX;
    else if (mclk_en)
    begin
      if (clear)
        idx_r <= `SARC_MSB_IDX;
      else if (tick && !last)
        idx_r <= idx_r - 4'h1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      successive_approx_register_r <= `SARC_RST_RESULT;
    else if (mclk_en)
    begin
      if (clear)
        successive_approx_register_r <= '0;
      else if (tick)
      begin
        successive_approx_register_r[idx_r] <= comp_below;
        if (last && short_cycle)
          successive_approx_register_r[3:0] <= `SARC_SHORT_FILL;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      eoc_r <= 1'b0;
    else if (mclk_en)
      eoc_r <= tick & last;
  end

endmodule

/* design/sarc_top.sv */
// Conversion control of a 12-bit successive approximation converter
// Assumes asynchronous control pins, one mclk domain and an AHB-Lite master
//
// Notes on behaviour
// - Start enables trial clock, clears register
// - Running conversion cannot be aborted or restarted
// - No result presented while converting
// - Sequencer flags end after last bit
// - End stops clock, drops busy
// - Reads accepted once busy falls
// - Bits tested from MSB down to LSB
// - Bit kept when trial is below input
// - Register holds final 12-bit result
// - High read pulse: outputs only while high
// - Low convert pulse: outputs after finish
// - Start when last of three conditions met
// - Length select latched at start
// - Start while busy is ignored
// - Width select chooses 12, 8 or 4+zeros
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "sarc_regs.svh"

module sarc_top
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic                mclk_en,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Converter pins
  input  wire sarc_pkg::sarc_pins_s pins,
  output logic [`SARC_RES_W-1:0]   result_bus,
  output logic                     result_bus_oe,
  output logic                     conversion_busy_flag,
  output logic [`SARC_RES_W-1:0]   dac_trial,
  // Interrupt
  output logic                     irq
);
  import sarc_pkg::*;

  localparam int PIN_W = $bits(sarc_pins_s);

  // Register bus address match
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  // Pin synchronisers
  logic [PIN_W-1:0] sync1_r;
  logic [PIN_W-1:0] sync2_r;
  sarc_pins_s       pin_s;

  // Control state
  sarc_state_e      state_r;
  logic             busy_r;
  logic             short_r;
  logic             valid_r;
  logic             start_cond_d_r;
  logic             start_cond;
  logic             start_edge;
  logic             sw_start;
  logic             start_req;
  logic             accept;
  logic             ignored;
  logic             read_cond;

  // Sequencer link
  sarc_word_t       successive_approx_register;
  sarc_word_t       trial;
  logic             eoc;

  // Register bus state
  logic             ap_valid;
  logic             wr_pend_r;
  logic [7:0]       wr_addr_r;
  logic             wr_ctrl;
  logic             ctrl_short_r;
  logic [`SARC_IRQ_W-1:0] irq_stat_r;
  logic [`SARC_IRQ_W-1:0] irq_mask_r;
  logic [`SARC_IRQ_W-1:0] irq_set;
  logic [`SARC_IRQ_W-1:0] irq_clr;

  // Output flops
  logic [31:0]            hrdata_r;
  logic                   hreadyout_r;
  logic                   hresp_r;
  logic [`SARC_RES_W-1:0] result_bus_r;
  logic                   result_oe_r;
  logic [`SARC_RES_W-1:0] dac_trial_r;
  logic                   irq_r;

  // First stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (!nrst)
        begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end
        else if (mclk_en)
        begin
          sync1_r[gi] <= pins[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  assign pin_s = sync2_r;

  assign start_cond = pin_s.strobe_en & ~pin_s.select_n & ~pin_s.read_convert;
  assign start_edge = start_cond & ~start_cond_d_r;
  assign start_req  = start_edge | sw_start;
  assign accept     = start_req & ~busy_r;
  assign ignored    = start_req & busy_r;

  // Reset to one, but the synchronisers reset to zero, so a start level held through reset still gives a start edge
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      start_cond_d_r <= 1'b1;
    else if (mclk_en)
      start_cond_d_r <= start_cond;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      short_r <= `SARC_RST_SHORT;
    else if (mclk_en && accept)
      short_r <= start_edge ? pin_s.length_byte_select : hwdata[`SARC_CTRL_SHORT];
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      state_r <= st_idle;
    else if (mclk_en)
    begin
      case (state_r)
        st_idle:
          if (accept)
            state_r <= st_clear;
        st_clear:
          state_r <= st_run;
        st_run:
          if (eoc)
            state_r <= st_done;
        st_done:
          if (accept)
            state_r <= st_clear;
          else
            state_r <= st_idle;
        default:
          state_r <= st_idle;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      busy_r <= 1'b0;
    else if (mclk_en)
    begin
      if (accept)
        busy_r <= 1'b1;
      else if (eoc)
        busy_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      valid_r <= 1'b0;
    else if (mclk_en)
    begin
      if (accept)
        valid_r <= 1'b0;
      else if (eoc)
        valid_r <= 1'b1;
    end
  end

  sarc_seq u_seq
  (
    .mclk        (mclk),
    .nrst        (nrst),
    .mclk_en     (mclk_en),
    .clear       (state_r == st_clear),
    .run         (state_r == st_run),
    .short_cycle (short_r),
    .comp_below  (pin_s.comp_below),
    .successive_approx_register (successive_approx_register),
    .trial       (trial),
    .eoc         (eoc)
  );

  assign read_cond = pin_s.strobe_en & ~pin_s.select_n & pin_s.read_convert
                   & ~busy_r & ~accept;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      result_oe_r <= 1'b0;
    else if (mclk_en)
      result_oe_r <= read_cond;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      result_bus_r <= `SARC_RST_RESULT;
    else if (mclk_en)
    begin
      // Bus cleared from start edge on
      if (busy_r || accept)
        result_bus_r <= '0;
      else if (pin_s.width_sel)
        result_bus_r <= successive_approx_register;
      else if (!pin_s.length_byte_select)
        result_bus_r <= {successive_approx_register[11:4], 4'h0};
      else
        result_bus_r <= {successive_approx_register[3:0], 8'h00};
    end
  end

  // Trial word for the capacitor array
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      dac_trial_r <= '0;
    else if (mclk_en)
      dac_trial_r <= trial;
  end

  // Register bus: zero wait states, every response OKAY
  assign ap_valid = hsel & htrans[1] & hready;
  assign wr_ctrl  = wr_pend_r & reg_hit(wr_addr_r, `SARC_OFF_CTRL);
  assign sw_start = wr_ctrl & hwdata[`SARC_CTRL_START];

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else if (mclk_en)
    begin
      wr_pend_r <= ap_valid & hwrite;
      if (ap_valid)
        wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      ctrl_short_r <= `SARC_RST_SHORT;
    else if (mclk_en && wr_ctrl)
      ctrl_short_r <= hwdata[`SARC_CTRL_SHORT];
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      irq_mask_r <= `SARC_RST_MASK;
    else if (mclk_en && wr_pend_r && reg_hit(wr_addr_r, `SARC_OFF_IRQ_MASK))
      irq_mask_r <= hwdata[`SARC_IRQ_W-1:0];
  end

  // Set wins over a same-cycle write-one clear
  assign irq_set[`SARC_IRQ_DONE]    = eoc;
  assign irq_set[`SARC_IRQ_IGNORED] = ignored;
  assign irq_clr = (wr_pend_r && reg_hit(wr_addr_r, `SARC_OFF_IRQ_STAT))
                 ? hwdata[`SARC_IRQ_W-1:0] : '0;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      irq_stat_r <= '0;
    else if (mclk_en)
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      irq_r <= 1'b0;
    else if (mclk_en)
      irq_r <= |(irq_stat_r & irq_mask_r);
  end

  // Read data sampled in the address phase, so a write just before is not seen
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      hrdata_r <= 32'h0000_0000;
    else if (mclk_en && ap_valid && !hwrite)
    begin
      hrdata_r <= 32'h0000_0000;
      if (reg_hit(haddr[7:0], `SARC_OFF_CTRL))
        hrdata_r[`SARC_CTRL_SHORT] <= ctrl_short_r;
      else if (reg_hit(haddr[7:0], `SARC_OFF_STATUS))
      begin
        hrdata_r[`SARC_STAT_BUSY]  <= busy_r;
        hrdata_r[`SARC_STAT_SHORT] <= short_r;
        hrdata_r[`SARC_STAT_VALID] <= valid_r;
        hrdata_r[`SARC_STAT_STATE +: 2] <= state_r;
      end
      else if (reg_hit(haddr[7:0], `SARC_OFF_RESULT))
        hrdata_r[`SARC_RES_W-1:0] <= valid_r ? successive_approx_register : '0;
      else if (reg_hit(haddr[7:0], `SARC_OFF_IRQ_STAT))
        hrdata_r[`SARC_IRQ_W-1:0] <= irq_stat_r;
      else if (reg_hit(haddr[7:0], `SARC_OFF_IRQ_MASK))
        hrdata_r[`SARC_IRQ_W-1:0] <= irq_mask_r;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
    else if (mclk_en)
    begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  assign hrdata               = hrdata_r;
  assign hreadyout            = hreadyout_r;
  assign hresp                = hresp_r;
  assign result_bus           = result_bus_r;
  assign result_bus_oe        = result_oe_r;
  assign conversion_busy_flag = busy_r;
  assign dac_trial            = dac_trial_r;
  assign irq                  = irq_r;

endmodule

/* sim/sarc_chk.sv */
// Checker of busy length, trial order and output enable
// Assumes binding into sarc_top and one mclk domain
`timescale 1ns/100ps

module sarc_chk
(
  // Clock and reset
  input wire logic                 mclk,
  input wire logic                 nrst,
  // Converter pins
  input wire sarc_pkg::sarc_pins_s pins,
  input wire sarc_pkg::sarc_word_t result_bus,
  input wire logic                 result_bus_oe,
  input wire logic                 conversion_busy_flag,
  input wire sarc_pkg::sarc_word_t dac_trial
);
  import sarc_pkg::*;
  logic       busy;
  logic [7:0] run_cnt_r;
  assign busy = conversion_busy_flag;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Counts busy cycles; a restart would stretch it
  always_ff @(posedge mclk)
  begin
    if (!nrst || !busy)
      run_cnt_r <= 8'h00;
    else
      run_cnt_r <= run_cnt_r + 8'h01;
  end
  chk_busy_no_oe: assert property (busy |-> !result_bus_oe)
    else $error("oe while busy");
  chk_busy_bus_zero: assert property (busy |-> result_bus == 12'h000)
    else $error("data while busy");
  chk_run_length: assert property
    ($fell(busy) |-> run_cnt_r inside {8'h7A, 8'hB6})
    else $error("busy length");
  chk_run_bound: assert property (busy |-> run_cnt_r < 8'hB6)
    else $error("busy too long");
  chk_first_trial: assert property ($rose(busy) |-> ##[1:6] dac_trial == 12'h800)
    else $error("first trial");
  chk_second_trial: assert property
    (busy && dac_trial == 12'h800 |-> ##[1:17] dac_trial[10:0] == 11'h400)
    else $error("second trial");
  chk_oe_needs_read: assert property (!pins.read_convert [*4] |-> !result_bus_oe)
    else $error("oe without read");
  chk_oe_after_end: assert property
    ($fell(busy) && pins.read_convert && pins.strobe_en && !pins.select_n |-> ##[0:4] result_bus_oe)
    else $error("no oe after end");
  chk_start_busy: assert property
    ($rose(pins.strobe_en && !pins.select_n && !pins.read_convert) && !busy |-> ##[1:6] busy)
    else $error("start missed");
  cover property ($fell(busy) && run_cnt_r == 8'h7A);
  cover property ($fell(busy) && run_cnt_r == 8'hB6);
  cover property ($rose(result_bus_oe));
endmodule

bind sarc_top sarc_chk sarc_chk_inst
(
  .mclk(mclk), .nrst(nrst), .pins(pins), .result_bus(result_bus),
  .result_bus_oe(result_bus_oe), .conversion_busy_flag(conversion_busy_flag),
  .dac_trial(dac_trial)
);

/* sim/sarc_partner.sv */
// Comparator and analog input facing the trial word
// Assumes the input code is held during a conversion
`timescale 1ns/100ps

module sarc_partner
(
  // Clock
  input wire logic                 mclk,
  // Analog side
  input wire sarc_pkg::sarc_word_t dac_trial,
  input wire sarc_pkg::sarc_word_t vin,
  input wire logic [3:0]           lag,
  output logic                     comp_below
);
  import sarc_pkg::*;
  sarc_word_t last_r = 12'h000;
  logic [3:0] age_r = 4'h0;
  // Wrong sense until settled, so early sampling shows up
  always @(posedge mclk)
  begin
    last_r <= dac_trial;
    age_r <= (dac_trial != last_r) ? 4'h0 : (age_r < lag) ? age_r + 4'h1 : age_r;
  end
  assign comp_below = (age_r < lag) ^ (dac_trial < vin);
endmodule

/* sim/sarc_top_test.sv */
// Bench: bus and pin conversions against a reference model
// Assumes sarc_top, sarc_partner and the bound checker
`timescale 1ns/100ps
`include "sarc_regs.svh"

module sarc_top_test;
  import sarc_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, result_bus_oe, conversion_busy_flag, irq, cb;
  logic        stb = 1'b0, sel_n = 1'b0, rdc = 1'b1, lbs = 1'b0, wsel = 1'b1;
  logic        rd_dp = 1'b0, oe_q = 1'b0;
  sarc_word_t  result_bus, dac_trial, res, v;
  sarc_word_t  vin = 12'h000;
  logic [3:0]  lag = 4'h0;
  sarc_pins_s  pins;
  logic [31:0] exp_rd[$], exp_pin[$];
  int          err_total = 0, check_count = 0, seed = 79294, i, j, f;

  initial forever #20 mclk = ~mclk;
  assign pins = {cb, wsel, lbs, rdc, sel_n, stb};

  sarc_top sarc_top_inst
  (
    .mclk(mclk), .nrst(nrst), .mclk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .result_bus(result_bus),
    .result_bus_oe(result_bus_oe), .conversion_busy_flag(conversion_busy_flag),
    .dac_trial(dac_trial), .irq(irq)
  );
  sarc_partner sarc_partner_inst
  (
    .mclk(mclk), .dac_trial(dac_trial), .vin(vin), .lag(lag), .comp_below(cb)
  );

  task automatic print_verdict();
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic pick(input int s);
    return s == 0 ? conversion_busy_flag : s == 1 ? result_bus_oe : hreadyout;
  endfunction

  // Bounded wait for a level, checked at rising edges
  task automatic wait_sig(input int s, input logic lvl);
    int n;
    n = 0;
    @(posedge mclk);
    while (pick(s) !== lvl)
    begin
      @(posedge mclk);
      n++;
      if (n > 400)
      begin
        err_total++;
        print_verdict();
      end
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Reads pass the expected word in d
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w)
      exp_rd.push_back(d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_sig(2, 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_sig(2, 1'b1);
  endtask

  function automatic sarc_word_t approx_ref(input sarc_word_t x, input logic s);
    sarc_word_t r;
    r = 12'h000;
    for (int k = 11; k >= (s ? 4 : 0); k--)
      if ((r | (12'h001 << k)) < x)
        r = r | (12'h001 << k);
    if (s)
      r[3:0] = 4'h8;
    return r;
  endfunction

  function automatic logic [31:0] fmt(input logic w, input logic l, input sarc_word_t r);
    return {20'h0, w ? r : l ? {r[3:0], 8'h00} : {r[11:4], 4'h0}};
  endfunction

  always @(posedge mclk)
  begin
    if (rd_dp && hreadyout === 1'b1)
    begin
      cmp("hrdata", exp_rd.pop_front(), hrdata);
      cmp("hresp", 32'h0, {31'h0, hresp});
    end
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
    if (result_bus_oe && !oe_q)
      cmp("result_bus", exp_pin.pop_front(), {20'h0, result_bus});
    oe_q <= result_bus_oe;
  end

  initial
  begin
    step(8);
    nrst <= 1'b1;
    for (i = 1; i < 6; i++)
      ahb(1'b0, 8'(4 * i), 32'h0);
    for (i = 0; i < 6; i++)
    begin
      res = i == 0 ? 12'hFFF : i == 1 ? 12'h000 : 12'($random(seed));
      vin <= res;
      lag <= 4'({$random(seed)} % 9);
      ahb(1'b1, `SARC_OFF_CTRL, {30'h0, i[0], 1'b1});
      wait_sig(0, 1'b1);
      ahb(1'b0, `SARC_OFF_RESULT, 32'h0);
      wait_sig(0, 1'b0);
      res = approx_ref(vin, i[0]);
      ahb(1'b0, `SARC_OFF_RESULT, {20'h0, res});
      ahb(1'b0, `SARC_OFF_RESULT, {20'h0, res});
    end
    ahb(1'b0, `SARC_OFF_IRQ_STAT, 32'h1);
    cmp("irq", 32'h0, {31'h0, irq});
    ahb(1'b1, `SARC_OFF_IRQ_MASK, 32'h3);
    step(2);
    cmp("irq", 32'h1, {31'h0, irq});
    ahb(1'b1, `SARC_OFF_IRQ_STAT, 32'h3);
    step(2);
    cmp("irq", 32'h0, {31'h0, irq});
    // Each pass starts by a different pin, that pin last
    for (j = 0; j < 3; j++)
    begin
      v = 12'($random(seed));
      vin <= v;
      if (j == 2)
        exp_pin.push_back(fmt(1'b0, 1'b0, res));
      stb <= j != 0;
      sel_n <= j == 1;
      rdc <= j == 2;
      lbs <= j == 1;
      step(6);
      stb <= 1'b1;
      sel_n <= 1'b0;
      rdc <= 1'b0;
      wait_sig(0, 1'b1);
      lbs <= j != 1;
      step(4);
      stb <= j != 0;
      sel_n <= j == 1;
      rdc <= j == 2;
      step(5);
      stb <= 1'b1;
      sel_n <= 1'b0;
      rdc <= 1'b0;
      step(5);
      res = approx_ref(v, j == 1);
      exp_pin.push_back({20'h0, res});
      rdc <= 1'b1;
      wsel <= 1'b1;
      wait_sig(1, 1'b1);
      for (f = 0; f < 3; f++)
      begin
        stb <= 1'b0;
        wait_sig(1, 1'b0);
        wsel <= f == 0;
        lbs <= f == 2;
        exp_pin.push_back(fmt(f == 0, f == 2, res));
        stb <= 1'b1;
        wait_sig(1, 1'b1);
      end
      stb <= 1'b0;
      wait_sig(1, 1'b0);
    end
    ahb(1'b0, `SARC_OFF_IRQ_STAT, 32'h3);
    cmp("irq", 32'h1, {31'h0, irq});
    step(2);
    print_verdict();
  end
endmodule
